/* shared/pxc_pkg.sv */
// Purpose: constants for the PHY extended control and interrupt mask bank
// Assumes: register indices are word indices; byte address is index times four
// Notes: none
`default_nettype none
package pxc_pkg;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int SRC_W = 16;
  // ==========================================
  // Register word indices
  localparam logic [7:0] IDX_CTRL10 = 8'h16;
  localparam logic [7:0] IDX_CTRL1 = 8'h17;
  localparam logic [7:0] IDX_CTRL2 = 8'h18;
  localparam logic [7:0] IDX_IMASK = 8'h19;
  localparam logic [7:0] IDX_ISTAT = 8'h1A;
  // ==========================================
  // Field positions
  localparam int B_LINK_DIS = 15;
  localparam int B_JAB_DIS = 14;
  localparam int B_ECHO_DIS = 13;
  localparam int B_SQE_DIS = 12;
  localparam int B_SQL_LSB = 10;
  localparam int B_STICKY = 9;
  localparam int B_EOF = 8;
  localparam int B_DISC = 7;
  localparam int B_LINK = 6;
  localparam int B_CRS_LSB = 1;
  localparam int B_FAR_LB = 3;
  localparam int B_EDGE_LSB = 13;
  localparam int B_JUMBO_LSB = 4;
  localparam int B_CABLE_LB = 0;
  localparam int B_IRQ_EN = 15;
  // ==========================================
  // Reset values and writable bits
  localparam logic [15:0] RST_CTRL10 = 16'h3200;
  localparam logic [15:0] RST_CTRL1 = 16'h0000;
  localparam logic [15:0] RST_CTRL2 = 16'h0000;
  localparam logic [15:0] RST_IMASK = 16'h0000;
  localparam logic [15:0] WM_CTRL10 = 16'hFE06;
  localparam logic [15:0] WM_CTRL1 = 16'h0008;
  localparam logic [15:0] WM_CTRL2 = 16'hE031;
  localparam logic [15:0] WM_IMASK = 16'hFFBF;
  localparam logic [15:0] SRC_VALID = 16'h7FBF;
  localparam logic [1:0] CODE_RSVD = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================
  // Carrier-sense equation codes
  typedef enum logic [1:0] {
    PXC_CRS_RX_OR_HDX_TX = 2'h0,
    PXC_CRS_ANY_HDX = 2'h1,
    PXC_CRS_RX_ONLY = 2'h2,
    PXC_CRS_RX_HDX = 2'h3
  } pxc_crs_t;
endpackage
`default_nettype wire

/* hw/pxc_crs.sv */
// Purpose: carrier-sense equation select
// Assumes: inputs synchronous to aclk
// Notes: output registered
`timescale 1ns/1ps
`default_nettype none
module pxc_crs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] crs_code,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic full_duplex_flag,
  output logic carrier_sense
);
  import pxc_pkg::*;
  logic next_crs;
  wire hdx = !full_duplex_flag;
  always_comb begin
    case (pxc_crs_t'(crs_code))
      PXC_CRS_RX_OR_HDX_TX: next_crs = rx_active | (tx_active & hdx);
      PXC_CRS_ANY_HDX: next_crs = (rx_active | tx_active) & hdx;
      PXC_CRS_RX_ONLY: next_crs = rx_active;
      PXC_CRS_RX_HDX: next_crs = rx_active & hdx;
      default: next_crs = rx_active;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) carrier_sense <= 1'b0;
    else carrier_sense <= next_crs;
  end
endmodule // pxc_crs
`default_nettype wire

/* hw/pxc_irq.sv */
// Purpose: pending latch, masked status view and interrupt line
// Assumes: evt bits are one-cycle pulses; rd_clr marks a status read
// Notes: an event in the clearing cycle stays pending
`timescale 1ns/1ps
`default_nettype none
module pxc_irq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] evt,
  input wire logic [15:0] mask,
  input wire logic rd_clr,
  output logic [15:0] status_word,
  output logic [15:0] pending,
  output logic irq
);
  import pxc_pkg::*;
  wire [15:0] live_mask = mask & SRC_VALID;
  wire [15:0] clr_bits = rd_clr ? live_mask : 16'h0000;
  wire [15:0] next_pending = (pending & ~clr_bits) | (evt & SRC_VALID);
  wire [15:0] shown = pending & live_mask;
  wire summary = mask[B_IRQ_EN] & (|shown);
  assign status_word = {summary, shown[14:0]};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= 16'h0000;
      irq <= 1'b0;
    end else begin
      pending <= next_pending;
      irq <= summary;
    end
  end
endmodule // pxc_irq
`default_nettype wire

/* hw/pxc_regs.sv */
// Purpose: AXI4-Lite bank for PHY extended control, status and interrupts
// Assumes: event inputs are one-cycle pulses synchronous to aclk
// Notes: byte address = register index times four; wstrb[1:0] used
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pxc_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pxc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pxc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic eof_err_evt,
  input wire logic tenbase_disc_evt,
  input wire logic tenbase_link_up,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic full_duplex_flag,
  input wire logic [pxc_pkg::SRC_W-1:0] irq_evt,
  output logic link_integ_dis,
  output logic jabber_dis,
  output logic echo_dis,
  output logic sqe_test_dis,
  output logic [1:0] squelch_sel,
  output logic sticky_rst_en,
  output logic carrier_sense,
  output logic far_end_lpbk,
  output logic [2:0] edge_rate,
  output logic [1:0] jumbo_sel,
  output logic cable_lpbk,
  output logic irq
);
  import pxc_pkg::*;

  if (ADDR_W < 7) begin : g_addr_chk
    $error("ADDR_W too small for the register map");
  end

  // ==========================================
  // Helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] st,
                                        input logic [15:0] wm);
    logic [15:0] nw;
    nw = old;
    if (st[0]) nw[7:0] = wd[7:0];
    if (st[1]) nw[15:8] = wd[15:8];
    merge = (nw & wm) | (old & ~wm);
  endfunction

  // Reserved two-bit code leaves the field as it was
  function automatic logic [1:0] keep_rsvd(input logic [1:0] old, input logic [1:0] nw);
    keep_rsvd = (nw == CODE_RSVD) ? old : nw;
  endfunction

  // ==========================================
  // Write channel
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire b_hs = s_axi_bvalid & s_axi_bready;
  wire wr_fire = aw_held & w_held & !s_axi_bvalid;
  wire next_aw_held = (aw_held | aw_hs) & !wr_fire;
  wire next_w_held = (w_held | w_hs) & !wr_fire;
  wire next_bvalid = wr_fire | (s_axi_bvalid & !s_axi_bready);

  wire wr_c10 = wr_fire & hit(awaddr_q, IDX_CTRL10);
  wire wr_c1 = wr_fire & hit(awaddr_q, IDX_CTRL1);
  wire wr_c2 = wr_fire & hit(awaddr_q, IDX_CTRL2);
  wire wr_msk = wr_fire & hit(awaddr_q, IDX_IMASK);
  wire wr_sts = wr_fire & hit(awaddr_q, IDX_ISTAT);
  wire wr_ok = wr_c10 | wr_c1 | wr_c2 | wr_msk | wr_sts;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= !next_aw_held & !next_bvalid;
      s_axi_wready <= !next_w_held & !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (wr_fire) s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_hs) awaddr_q <= s_axi_awaddr;
      if (w_hs) wdata_q <= s_axi_wdata;
      if (w_hs) wstrb_q <= s_axi_wstrb;
    end
  end

  // ==========================================
  // Control registers
  logic [15:0] ctrl10_q;
  logic [15:0] ctrl1_q;
  logic [15:0] ctrl2_q;
  logic [15:0] imask_q;

  wire [15:0] c10_m = merge(ctrl10_q, wdata_q, wstrb_q, WM_CTRL10);
  wire [15:0] c2_m = merge(ctrl2_q, wdata_q, wstrb_q, WM_CTRL2);
  wire [1:0] sql_new = keep_rsvd(ctrl10_q[B_SQL_LSB +: 2], c10_m[B_SQL_LSB +: 2]);
  wire [1:0] jmb_new = keep_rsvd(ctrl2_q[B_JUMBO_LSB +: 2], c2_m[B_JUMBO_LSB +: 2]);
  wire [15:0] next_c10 = {c10_m[15:12], sql_new, c10_m[9:0]};
  wire [15:0] next_c2 = {c2_m[15:6], jmb_new, c2_m[3:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl10_q <= RST_CTRL10;
      ctrl1_q <= RST_CTRL1;
      ctrl2_q <= RST_CTRL2;
      imask_q <= RST_IMASK;
    end else begin
      if (wr_c10) ctrl10_q <= next_c10;
      if (wr_c1) ctrl1_q <= merge(ctrl1_q, wdata_q, wstrb_q, WM_CTRL1);
      if (wr_c2) ctrl2_q <= next_c2;
      if (wr_msk) imask_q <= merge(imask_q, wdata_q, wstrb_q, WM_IMASK);
    end
  end

  assign link_integ_dis = ctrl10_q[B_LINK_DIS];
  assign jabber_dis = ctrl10_q[B_JAB_DIS];
  assign echo_dis = ctrl10_q[B_ECHO_DIS];
  assign sqe_test_dis = ctrl10_q[B_SQE_DIS];
  assign squelch_sel = ctrl10_q[B_SQL_LSB +: 2];
  assign sticky_rst_en = ctrl10_q[B_STICKY];
  assign far_end_lpbk = ctrl1_q[B_FAR_LB];
  assign edge_rate = ctrl2_q[B_EDGE_LSB +: 3];
  assign jumbo_sel = ctrl2_q[B_JUMBO_LSB +: 2];
  assign cable_lpbk = ctrl2_q[B_CABLE_LB];

  // ==========================================
  // Read channel
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire next_rvalid = ar_hs | (s_axi_rvalid & !s_axi_rready);
  wire rd_c10 = ar_hs & hit(s_axi_araddr, IDX_CTRL10);
  wire rd_sts = ar_hs & hit(s_axi_araddr, IDX_ISTAT);

  logic eof_flag;
  logic disc_flag;
  logic [15:0] status_word;
  logic [15:0] pending;

  // Event in the reading cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eof_flag <= 1'b0;
      disc_flag <= 1'b0;
    end else begin
      eof_flag <= (eof_flag & !rd_c10) | eof_err_evt;
      disc_flag <= (disc_flag & !rd_c10) | tenbase_disc_evt;
    end
  end

  wire [15:0] c10_view = {ctrl10_q[15:9], eof_flag, disc_flag, tenbase_link_up,
                          3'h0, ctrl10_q[2:1], 1'b0};
  wire [15:0] rd_word =
    hit(s_axi_araddr, IDX_CTRL10) ? c10_view :
    hit(s_axi_araddr, IDX_CTRL1) ? (ctrl1_q & WM_CTRL1) :
    hit(s_axi_araddr, IDX_CTRL2) ? (ctrl2_q & WM_CTRL2) :
    hit(s_axi_araddr, IDX_IMASK) ? (imask_q & WM_IMASK) :
    hit(s_axi_araddr, IDX_ISTAT) ? status_word : 16'h0000;
  wire rd_ok = hit(s_axi_araddr, IDX_CTRL10) | hit(s_axi_araddr, IDX_CTRL1) |
               hit(s_axi_araddr, IDX_CTRL2) | hit(s_axi_araddr, IDX_IMASK) |
               hit(s_axi_araddr, IDX_ISTAT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_hs) s_axi_rdata <= {16'h0000, rd_word};
      if (ar_hs) s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ==========================================
  // Interrupt and carrier sense
  pxc_irq u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt(irq_evt),
    .mask(imask_q),
    .rd_clr(rd_sts),
    .status_word(status_word),
    .pending(pending),
    .irq(irq)
  );

  pxc_crs u_crs (
    .aclk(aclk),
    .aresetn(aresetn),
    .crs_code(ctrl10_q[B_CRS_LSB +: 2]),
    .rx_active(rx_active),
    .tx_active(tx_active),
    .full_duplex_flag(full_duplex_flag),
    .carrier_sense(carrier_sense)
  );

  // ==========================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_link_dis_write: assert property (
    wr_c10 && wstrb_q[1] |=> link_integ_dis == $past(wdata_q[15]))
    else $error("link integrity disable not written");

  a_echo_sqe_hold: assert property (
    !wr_c10 |=> echo_dis == $past(echo_dis) && sqe_test_dis == $past(sqe_test_dis))
    else $error("echo or sqe disable changed without write");

  a_squelch_rsvd: assert property (
    squelch_sel != CODE_RSVD && jumbo_sel != CODE_RSVD)
    else $error("reserved code stored");

  a_eof_latch: assert property (
    eof_err_evt |=> eof_flag)
    else $error("eof event not latched");

  a_disc_clear: assert property (
    rd_c10 && !tenbase_disc_evt |=> !disc_flag)
    else $error("disconnect flag not cleared by read");

  a_link_live: assert property (
    rd_c10 |=> s_axi_rdata[B_LINK] == $past(tenbase_link_up))
    else $error("link state read mismatch");

  a_crs_eq: assert property (
    ctrl10_q[2:1] == 2'h2 && $stable(ctrl10_q) |=> carrier_sense == $past(rx_active))
    else $error("carrier sense receive-only wrong");

  a_far_lb_write: assert property (
    wr_c1 && wstrb_q[0] |=> far_end_lpbk == $past(wdata_q[3]))
    else $error("far end loopback not written");

  a_irq_gate: assert property (
    !imask_q[B_IRQ_EN] |=> !irq)
    else $error("interrupt asserted with master enable clear");

  a_mask_hides: assert property (
    irq_evt[0] && !imask_q[0] |=> pending[0] && (imask_q[0] || !status_word[0]))
    else $error("masked source not held pending");

  a_mask_reveal: assert property (
    pending[1] && imask_q[1] |-> status_word[1])
    else $error("pending source not shown when unmasked");

  a_rd_keeps_masked: assert property (
    rd_sts && pending[1] && !imask_q[1] |=> pending[1])
    else $error("masked pending cleared by read");

  a_rsvd_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper data bits not zero");

  a_write_resp: assert property (
    wr_fire |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
    else $error("write response missing");

  a_jabber_write: assert property (
    wr_c10 && wstrb_q[1] |=> jabber_dis == $past(wdata_q[14]))
    else $error("jabber disable not written");

  a_edge_write: assert property (
    wr_c2 && wstrb_q[1] |=> edge_rate == $past(wdata_q[15:13]))
    else $error("edge rate not written");

  a_jumbo_write: assert property (
    wr_c2 && wstrb_q[0] && wdata_q[5:4] != CODE_RSVD |=> jumbo_sel == $past(wdata_q[5:4]))
    else $error("jumbo length not written");

  a_cable_lb_write: assert property (
    wr_c2 && wstrb_q[0] |=> cable_lpbk == $past(wdata_q[0]))
    else $error("cable loopback not written");

  a_mask_write: assert property (
    wr_msk && wstrb_q[1:0] == 2'h3 |=> imask_q == $past(wdata_q[15:0] & WM_IMASK))
    else $error("interrupt mask not written");

  a_rd_clears: assert property (
    rd_sts && pending[0] && imask_q[0] && !irq_evt[0] |=> !pending[0])
    else $error("unmasked pending not cleared by read");

  a_irq_follow: assert property (
    imask_q[B_IRQ_EN] && (|status_word[14:0]) |=> irq)
    else $error("interrupt not raised for enabled status");
endmodule // pxc_regs
`default_nettype wire

/* tb/phy_ext_ctrl_irq_mask_regs_bench.sv */
// Purpose: self-checking bench for the PHY extended control and interrupt mask bank
// Assumes: AXI4-Lite master driven by non-blocking assignment after each rising edge
// Notes: byte address is register index times four; reserved codes leave fields unchanged
`timescale 1ns/1ps
`default_nettype none
module phy_ext_ctrl_irq_mask_regs_bench;
  import pxc_pkg::*;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, squelch_sel, jumbo_sel;
  logic eof_err_evt, tenbase_disc_evt, tenbase_link_up, rx_active, tx_active, full_duplex_flag;
  logic [15:0] irq_evt;
  logic link_integ_dis, jabber_dis, echo_dis, sqe_test_dis, sticky_rst_en, carrier_sense;
  logic far_end_lpbk, cable_lpbk, irq;
  logic [2:0] edge_rate;
  int errors, total_checks;
  logic [31:0] rd;
  logic [1:0] rs;

  pxc_regs #(.ADDR_W(8)) pxc_regs_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .eof_err_evt(eof_err_evt), .tenbase_disc_evt(tenbase_disc_evt),
    .tenbase_link_up(tenbase_link_up), .rx_active(rx_active), .tx_active(tx_active),
    .full_duplex_flag(full_duplex_flag), .irq_evt(irq_evt),
    .link_integ_dis(link_integ_dis), .jabber_dis(jabber_dis), .echo_dis(echo_dis),
    .sqe_test_dis(sqe_test_dis), .squelch_sel(squelch_sel), .sticky_rst_en(sticky_rst_en),
    .carrier_sense(carrier_sense), .far_end_lpbk(far_end_lpbk), .edge_rate(edge_rate),
    .jumbo_sel(jumbo_sel), .cable_lpbk(cable_lpbk), .irq(irq)
  );

  always #2.5 aclk = ~aclk;

  // ==========================================
  // Checking and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================
  // AXI4-Lite master
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    axi_write({idx[5:0], 2'b00}, d, rs);
    check("bresp", {30'h0, rs}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    axi_read({idx[5:0], 2'b00}, rd, rs);
    check(name, rd, exp);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset_values();
    rd_chk("ctrl10 reset", IDX_CTRL10, 32'h0000_3200);
    rd_chk("ctrl1 reset", IDX_CTRL1, 32'h0000_0000);
    rd_chk("ctrl2 reset", IDX_CTRL2, 32'h0000_0000);
    rd_chk("imask reset", IDX_IMASK, 32'h0000_0000);
    check("ctrl outs", {27'h0, link_integ_dis, jabber_dis, echo_dis, sqe_test_dis, sticky_rst_en},
          32'h7);
  endtask

  task automatic t_ctrl10_fields();
    wr(IDX_CTRL10, 32'hFFFF_FFFF);
    rd_chk("ctrl10 ones", IDX_CTRL10, 32'h0000_F206);
    check("ctrl outs", {27'h0, link_integ_dis, jabber_dis, echo_dis, sqe_test_dis, sticky_rst_en},
          32'h1F);
    check("squelch rsvd", {30'h0, squelch_sel}, 32'h0);
    wr(IDX_CTRL10, 32'h0000_0400);
    check("squelch 01", {30'h0, squelch_sel}, 32'h1);
    wr(IDX_CTRL10, 32'h0000_0800);
    rd_chk("ctrl10 sql", IDX_CTRL10, 32'h0000_0800);
    check("ctrl outs off", {27'h0, link_integ_dis, jabber_dis, echo_dis, sqe_test_dis,
          sticky_rst_en}, 32'h0);
  endtask

  task automatic t_link_flags();
    @(posedge aclk);
    eof_err_evt <= 1'b1;
    tenbase_disc_evt <= 1'b1;
    tenbase_link_up <= 1'b1;
    @(posedge aclk);
    eof_err_evt <= 1'b0;
    tenbase_disc_evt <= 1'b0;
    rd_chk("flags set", IDX_CTRL10, 32'h0000_09C0);
    rd_chk("flags clear", IDX_CTRL10, 32'h0000_0840);
    @(posedge aclk);
    tenbase_link_up <= 1'b0;
    rd_chk("link live", IDX_CTRL10, 32'h0000_0800);
  endtask

  task automatic t_crs();
    logic [2:0] v;
    logic e;
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CTRL10, {29'h0, c[1:0], 1'b0});
      for (int k = 0; k < 8; k++) begin
        v = k[2:0];
        case (c)
          0: e = v[0] | (v[1] & ~v[2]);
          1: e = (v[0] | v[1]) & ~v[2];
          2: e = v[0];
          default: e = v[0] & ~v[2];
        endcase
        @(posedge aclk);
        rx_active <= v[0];
        tx_active <= v[1];
        full_duplex_flag <= v[2];
        repeat (2) @(posedge aclk);
        check("carrier_sense", {31'h0, carrier_sense}, {31'h0, e});
      end
    end
  endtask

  task automatic t_ctrl12();
    wr(IDX_CTRL1, 32'hFFFF_FFFF);
    rd_chk("ctrl1 ones", IDX_CTRL1, 32'h0000_0008);
    check("far_end_lpbk", {31'h0, far_end_lpbk}, 32'h1);
    wr(IDX_CTRL2, 32'hFFFF_FFFF);
    rd_chk("ctrl2 ones", IDX_CTRL2, 32'h0000_E001);
    check("edge cable", {28'h0, edge_rate, cable_lpbk}, 32'hF);
    wr(IDX_CTRL2, 32'h0000_8020);
    rd_chk("ctrl2 codes", IDX_CTRL2, 32'h0000_8020);
    check("edge jumbo", {27'h0, edge_rate, jumbo_sel}, 32'h12);
    wr(IDX_CTRL1, 32'h0);
    check("far_end off", {31'h0, far_end_lpbk}, 32'h0);
    // Byte strobes: low byte only, then high byte only
    @(posedge aclk);
    s_axi_wstrb <= 4'h1;
    wr(IDX_CTRL2, 32'h0000_FFFF);
    rd_chk("ctrl2 low byte", IDX_CTRL2, 32'h0000_8021);
    s_axi_wstrb <= 4'h2;
    wr(IDX_CTRL2, 32'h0000_0000);
    rd_chk("ctrl2 high byte", IDX_CTRL2, 32'h0000_0021);
    s_axi_wstrb <= 4'hF;
  endtask

  task automatic t_irq();
    wr(IDX_IMASK, 32'hFFFF_FFFF);
    rd_chk("imask ones", IDX_IMASK, 32'h0000_FFBF);
    wr(IDX_IMASK, 32'h0);
    @(posedge aclk);
    irq_evt <= 16'h0003;
    @(posedge aclk);
    irq_evt <= 16'h0;
    rd_chk("masked status", IDX_ISTAT, 32'h0);
    // Enable sequence: masks first, flush, then master enable
    wr(IDX_IMASK, 32'h0000_0001);
    rd_chk("reveal pending", IDX_ISTAT, 32'h0000_0001);
    check("irq no enable", {31'h0, irq}, 32'h0);
    rd_chk("cleared src0", IDX_ISTAT, 32'h0);
    wr(IDX_IMASK, 32'h0000_8002);
    repeat (3) @(posedge aclk);
    check("irq set", {31'h0, irq}, 32'h1);
    rd_chk("kept src1", IDX_ISTAT, 32'h0000_8002);
    repeat (3) @(posedge aclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(IDX_IMASK, 32'h0000_0004);
    @(posedge aclk);
    irq_evt <= 16'h0004;
    @(posedge aclk);
    irq_evt <= 16'h0;
    repeat (3) @(posedge aclk);
    check("irq gated", {31'h0, irq}, 32'h0);
    rd_chk("no summary", IDX_ISTAT, 32'h0000_0004);
    // Unused source positions never become pending
    wr(IDX_IMASK, 32'h0000_FFFF);
    @(posedge aclk);
    irq_evt <= 16'h8040;
    @(posedge aclk);
    irq_evt <= 16'h0;
    rd_chk("unused sources", IDX_ISTAT, 32'h0);
    check("irq unused", {31'h0, irq}, 32'h0);
  endtask

  task automatic t_unmapped();
    axi_read(8'h70, rd, rs);
    check("unmapped rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    check("unmapped rdata", rd, 32'h0);
    axi_write(8'h70, 32'hFFFF_FFFF, rs);
    check("unmapped bresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    eof_err_evt = 1'b0;
    tenbase_disc_evt = 1'b0;
    tenbase_link_up = 1'b0;
    rx_active = 1'b0;
    tx_active = 1'b0;
    full_duplex_flag = 1'b0;
    irq_evt = 16'h0;
    errors = 0;
    total_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    t_ctrl10_fields();
    t_link_flags();
    t_crs();
    t_ctrl12();
    t_irq();
    t_unmapped();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    test_done();
  end
endmodule // phy_ext_ctrl_irq_mask_regs_bench
`default_nettype wire
